// File: ues_endpoint_status.sv
`include "ues_params.svh"

module ues_endpoint_status
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic I_SETUP_OK,
    input wire logic [7:0] I_SETUP_BYTE0,
    input wire logic I_OUT_STORED,
    input wire logic [`UES_CNT_W-1:0] I_OUT_BYTES,
    input wire logic I_OUT_CRC_ERR,
    input wire logic I_OUT_TOGGLE_ERR,
    input wire logic I_OUT_DROPPED,
    input wire logic I_IN_MISSED,
    input wire logic I_IN_SENT,
    input wire logic I_STALL_SENT,
    input wire logic I_NAK_IN,
    input wire logic I_NAK_OUT,
    input wire logic I_UFRAME_END,
    input wire logic I_FW_WRITE,
    input wire logic I_FW_READ,
    input wire logic I_PKT_REQ,
    output logic O_FORCE_STALL,
    output logic O_DESC_RD,
    output logic [31:0] O_DESC_ADDR,
    input wire logic I_DESC_RVALID,
    input wire logic [31:0] I_DESC_RDATA,
    output logic [31:0] O_DMA_CTRL
);
    import ues_pkg::*;

    logic [31:0] config_reg, config_next, rdata_reg, rdata_next, nxt_dsc_reg, nxt_dsc_next;
    logic [31:0] dma_buf_reg, dma_buf_next, dma_ctrl_reg, dma_ctrl_next, fetch_base_reg, fetch_base_next;
    logic [`UES_CNT_W-1:0] bank_cnt_reg [3];
    logic [`UES_CNT_W-1:0] bank_cnt_next [3];
    logic [`UES_CNT_W-1:0] byte_cnt_reg, byte_cnt_next;
    logic [2:0] bank_bad_reg, bank_bad_next;
    logic [1:0] cur_bank_reg, cur_bank_next, wr_bank_reg, wr_bank_next, busy_reg, busy_next;
    logic [1:0] valid_cnt_reg, valid_cnt_next;
    logic short_reg, short_next, ctrl_dir_reg, ctrl_dir_next, fstall_reg, fstall_next;
    logic setup_reg, setup_next, eflow_reg, eflow_next, stall_reg, stall_next, crc_reg, crc_next;
    logic nbtra_reg, nbtra_next, nak_in_reg, nak_in_next, flush_reg, flush_next, nak_out_reg, nak_out_next;
    logic sent_any_reg, sent_any_next;
    ues_desc_state_t dstate_reg, dstate_next;
    ues_word_idx_t widx_reg, widx_next;

    ues_ep_type_t ep_type;
    logic ep_in, is_iso, hb_iso, ep_clr;
    logic wr_clr, wr_set, rx_release, tx_validate;
    logic [1:0] banks;
    logic [31:0] status;

    function automatic logic [1:0] bank_inc(input logic [1:0] b, input logic [1:0] n);
        bank_inc = (b >= n - 2'h1) ? 2'h0 : b + 2'h1;
    endfunction

    always_comb
    begin
        ep_type = ues_ep_type_t'(config_reg[`UES_C_TYPE_HI:`UES_C_TYPE_LO]);
        ep_in = config_reg[`UES_C_DIR_IN];
        is_iso = (ep_type == UES_EP_ISO);
        hb_iso = is_iso && (config_reg[`UES_C_NBTR_HI:`UES_C_NBTR_LO] > 2'h1);
        banks = (config_reg[`UES_C_BANKS_HI:`UES_C_BANKS_LO] == 2'h0) ? 2'h1
              : config_reg[`UES_C_BANKS_HI:`UES_C_BANKS_LO];
        ep_clr = I_WR && ((I_ADDR == `UES_OFF_RESET) || (I_ADDR == `UES_OFF_DISABLE)) && I_WDATA[0];
        wr_clr = I_WR && (I_ADDR == `UES_OFF_CLEAR);
        wr_set = I_WR && (I_ADDR == `UES_OFF_SET);
        // A release on an empty OUT endpoint has nothing to switch to and is ignored.
        rx_release = wr_clr && I_WDATA[`UES_B_RXRDY] && !ep_in && (busy_reg != 2'h0);
        // Validation with all banks full is refused so the bank count never wraps.
        tx_validate = wr_set && I_WDATA[`UES_B_TXRDY] && ep_in && (busy_reg < banks);
    end

    always_comb
    begin
        status = 32'h0;
        status[`UES_B_SHORT] = short_reg;
        status[`UES_B_CNT_HI:`UES_B_CNT_LO] = byte_cnt_reg;
        status[`UES_B_BUSY_HI:`UES_B_BUSY_LO] = busy_reg;
        status[`UES_B_BANK_HI:`UES_B_BANK_LO] = (ep_type == UES_EP_CTRL) ? {1'b0, ctrl_dir_reg} : cur_bank_reg;
        status[`UES_B_NAK_OUT] = nak_out_reg;
        status[`UES_B_NAK_IN] = (hb_iso && ep_in) ? flush_reg : nak_in_reg;
        status[`UES_B_STALL] = !is_iso ? stall_reg : (ep_in ? nbtra_reg : crc_reg);
        status[`UES_B_SETUP] = is_iso ? eflow_reg : setup_reg;
        status[`UES_B_TXRDY] = (hb_iso && !ep_in) ? (bank_bad_reg[cur_bank_reg] && (busy_reg != 2'h0))
                             : (ep_in && (busy_reg != 2'h0));
        status[`UES_B_RXRDY] = !ep_in && (busy_reg != 2'h0);
        status[`UES_B_FSTALL] = fstall_reg;
    end

    always_comb
    begin
        config_next = config_reg;
        bank_cnt_next = bank_cnt_reg;
        bank_bad_next = bank_bad_reg;
        cur_bank_next = cur_bank_reg;
        wr_bank_next = wr_bank_reg;
        busy_next = busy_reg;
        byte_cnt_next = byte_cnt_reg;
        short_next = short_reg;
        ctrl_dir_next = ctrl_dir_reg;
        fstall_next = fstall_reg;
        setup_next = setup_reg;
        eflow_next = eflow_reg;
        stall_next = stall_reg;
        crc_next = crc_reg;
        nbtra_next = nbtra_reg;
        nak_in_next = nak_in_reg;
        flush_next = flush_reg;
        nak_out_next = nak_out_reg;
        valid_cnt_next = valid_cnt_reg;
        sent_any_next = sent_any_reg;
        nxt_dsc_next = nxt_dsc_reg;
        dma_buf_next = dma_buf_reg;
        dma_ctrl_next = dma_ctrl_reg;
        fetch_base_next = fetch_base_reg;
        dstate_next = dstate_reg;
        widx_next = widx_reg;
        rdata_next = 32'h0;

        // Software clears first; hardware events below override, so a set is lost only to an endpoint reset or disable, or a force-stall set to a SETUP.
        if (wr_clr)
        begin
            if (I_WDATA[`UES_B_SETUP])
            begin
                setup_next = 1'b0;
                eflow_next = 1'b0;
            end
            if (I_WDATA[`UES_B_STALL])
            begin
                stall_next = 1'b0;
                nbtra_next = 1'b0;
            end
            if (I_WDATA[`UES_B_NAK_IN])
            begin
                nak_in_next = 1'b0;
                flush_next = 1'b0;
            end
            if (I_WDATA[`UES_B_NAK_OUT])
                nak_out_next = 1'b0;
            if (I_WDATA[`UES_B_FSTALL])
                fstall_next = 1'b0;
        end
        if (wr_set && I_WDATA[`UES_B_FSTALL])
            fstall_next = 1'b1;
        if (I_WR && (I_ADDR == `UES_OFF_CONFIG))
            config_next = I_WDATA;
        if (I_WR && (I_ADDR == `UES_OFF_NEXT_DESC))
            nxt_dsc_next = I_WDATA & `UES_DESC_ALIGN_MASK;
        if (I_WR && (I_ADDR == `UES_OFF_DMA_CTRL))
            dma_ctrl_next = I_WDATA;
        if (I_WR && (I_ADDR == `UES_OFF_DMA_BUF))
            dma_buf_next = I_WDATA;

        // Firmware data port moves the live byte count.
        if (I_FW_WRITE && ep_in)
            byte_cnt_next = byte_cnt_reg + `UES_CNT_W'(1);
        else if (I_FW_READ && !ep_in && (byte_cnt_reg != `UES_CNT_W'(0)))
            byte_cnt_next = byte_cnt_reg - `UES_CNT_W'(1);

        // IN: firmware validates the bank it filled and moves to the next one.
        if (tx_validate)
        begin
            bank_cnt_next[cur_bank_reg] = byte_cnt_reg;
            cur_bank_next = bank_inc(cur_bank_reg, banks);
            byte_cnt_next = `UES_CNT_W'(0);
            // Saturates so that many refills in one microframe never wrap back below the target.
            valid_cnt_next = (valid_cnt_reg == 2'h3) ? 2'h3 : valid_cnt_reg + 2'h1;
        end
        if (I_IN_SENT && ep_in && (busy_reg != 2'h0))
            sent_any_next = 1'b1;
        busy_next = busy_reg + {1'b0, tx_validate} - {1'b0, I_IN_SENT && ep_in && (busy_reg != 2'h0)};

        // OUT: host stores banks in order, firmware releases them in order.
        if (rx_release)
        begin
            bank_bad_next[cur_bank_reg] = 1'b0;
            cur_bank_next = bank_inc(cur_bank_reg, banks);
            byte_cnt_next = bank_cnt_reg[bank_inc(cur_bank_reg, banks)];
            short_next = (bank_cnt_reg[bank_inc(cur_bank_reg, banks)]
                         < config_reg[`UES_C_SIZE_HI:`UES_C_SIZE_LO]) && (busy_reg > 2'h1);
        end
        if (I_OUT_STORED && !ep_in && (busy_reg < banks))
        begin
            bank_cnt_next[wr_bank_reg] = I_OUT_BYTES;
            bank_bad_next[wr_bank_reg] = hb_iso && I_OUT_TOGGLE_ERR;
            wr_bank_next = bank_inc(wr_bank_reg, banks);
            if (busy_reg == 2'h0 || (rx_release && busy_reg == 2'h1))
            begin
                byte_cnt_next = I_OUT_BYTES;
                short_next = I_OUT_BYTES < config_reg[`UES_C_SIZE_HI:`UES_C_SIZE_LO];
            end
            if (is_iso)
                crc_next = I_OUT_CRC_ERR;
        end
        if (!ep_in)
        begin
            busy_next = busy_reg + {1'b0, I_OUT_STORED && (busy_reg < banks)}
                      - {1'b0, rx_release};
        end

        // Hardware event flags.
        if (I_SETUP_OK && ep_type == UES_EP_CTRL)
        begin
            setup_next = 1'b1;
            ctrl_dir_next = I_SETUP_BYTE0[`UES_DIR_BIT];
            fstall_next = 1'b0;
        end
        if (is_iso && (I_IN_MISSED || I_OUT_DROPPED || (I_OUT_STORED && !ep_in && busy_reg >= banks)))
            eflow_next = 1'b1;
        if (I_STALL_SENT && !is_iso && fstall_reg)
            stall_next = 1'b1;
        if (I_NAK_IN)
            nak_in_next = 1'b1;
        if (I_NAK_OUT)
            nak_out_next = 1'b1;

        // Microframe boundary for high-bandwidth iso IN.
        if (I_UFRAME_END)
        begin
            valid_cnt_next = 2'h0;
            sent_any_next = 1'b0;
            if (hb_iso && ep_in)
            begin
                if (sent_any_reg && valid_cnt_reg < config_reg[`UES_C_NBTR_HI:`UES_C_NBTR_LO])
                    nbtra_next = 1'b1;
                if (busy_next != 2'h0)
                begin
                    flush_next = 1'b1;
                    busy_next = 2'h0;
                    cur_bank_next = 2'h0;
                end
            end
        end

        // Descriptor fetch: three consecutive words from the aligned pointer.
        unique case (dstate_reg)
            UES_D_IDLE:
            begin
                if (dma_ctrl_reg[`UES_DMA_B_LOAD] && I_PKT_REQ)
                begin
                    dstate_next = UES_D_REQ;
                    widx_next = 2'h0;
                    // Word 0 rewrites the pointer, so later words must use the base held here.
                    fetch_base_next = nxt_dsc_reg;
                end
            end
            UES_D_REQ: dstate_next = UES_D_WAIT;
            UES_D_WAIT:
            begin
                if (I_DESC_RVALID)
                begin
                    unique case (widx_reg)
                        2'h0: nxt_dsc_next = I_DESC_RDATA & `UES_DESC_ALIGN_MASK;
                        2'h1: dma_buf_next = I_DESC_RDATA;
                        default: dma_ctrl_next = I_DESC_RDATA;
                    endcase
                    widx_next = widx_reg + 2'h1;
                    dstate_next = (widx_reg == 2'h2) ? UES_D_IDLE : UES_D_REQ;
                end
            end
        endcase

        // Reset or disable wipes endpoint state except the force-stall and control-direction bits and the per-bank byte counts, overriding every other event on it.
        if (ep_clr)
        begin
            bank_bad_next = 3'h0;
            cur_bank_next = 2'h0;
            wr_bank_next = 2'h0;
            busy_next = 2'h0;
            byte_cnt_next = `UES_CNT_W'(0);
            short_next = 1'b0;
            setup_next = 1'b0;
            eflow_next = 1'b0;
            stall_next = 1'b0;
            crc_next = 1'b0;
            nbtra_next = 1'b0;
            nak_in_next = 1'b0;
            flush_next = 1'b0;
            nak_out_next = 1'b0;
            valid_cnt_next = 2'h0;
            sent_any_next = 1'b0;
        end

        // Read mux; the status word has no write decode at all.
        if (I_RD)
        begin
            unique case (I_ADDR)
                `UES_OFF_STATUS: rdata_next = status;
                `UES_OFF_CONFIG: rdata_next = config_reg;
                `UES_OFF_NEXT_DESC: rdata_next = nxt_dsc_reg;
                `UES_OFF_DMA_CTRL: rdata_next = dma_ctrl_reg;
                `UES_OFF_DMA_BUF: rdata_next = dma_buf_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            config_reg <= `UES_CONFIG_RESET;
            bank_cnt_reg <= '{default: '0};
            bank_bad_reg <= 3'h0;
            cur_bank_reg <= 2'h0;
            wr_bank_reg <= 2'h0;
            busy_reg <= 2'h0;
            byte_cnt_reg <= '0;
            short_reg <= 1'b0;
            ctrl_dir_reg <= 1'b0;
            fstall_reg <= 1'b0;
            setup_reg <= 1'b0;
            eflow_reg <= 1'b0;
            stall_reg <= 1'b0;
            crc_reg <= 1'b0;
            nbtra_reg <= 1'b0;
            nak_in_reg <= 1'b0;
            flush_reg <= 1'b0;
            nak_out_reg <= 1'b0;
            valid_cnt_reg <= 2'h0;
            sent_any_reg <= 1'b0;
            rdata_reg <= 32'h0;
            nxt_dsc_reg <= 32'h0;
            dma_buf_reg <= 32'h0;
            dma_ctrl_reg <= 32'h0;
            fetch_base_reg <= 32'h0;
            dstate_reg <= UES_D_IDLE;
            widx_reg <= 2'h0;
        end
        else
        begin
            config_reg <= config_next;
            bank_cnt_reg <= bank_cnt_next;
            bank_bad_reg <= bank_bad_next;
            cur_bank_reg <= cur_bank_next;
            wr_bank_reg <= wr_bank_next;
            busy_reg <= busy_next;
            byte_cnt_reg <= byte_cnt_next;
            short_reg <= short_next;
            ctrl_dir_reg <= ctrl_dir_next;
            fstall_reg <= fstall_next;
            setup_reg <= setup_next;
            eflow_reg <= eflow_next;
            stall_reg <= stall_next;
            crc_reg <= crc_next;
            nbtra_reg <= nbtra_next;
            nak_in_reg <= nak_in_next;
            flush_reg <= flush_next;
            nak_out_reg <= nak_out_next;
            valid_cnt_reg <= valid_cnt_next;
            sent_any_reg <= sent_any_next;
            rdata_reg <= rdata_next;
            nxt_dsc_reg <= nxt_dsc_next;
            dma_buf_reg <= dma_buf_next;
            dma_ctrl_reg <= dma_ctrl_next;
            fetch_base_reg <= fetch_base_next;
            dstate_reg <= dstate_next;
            widx_reg <= widx_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_FORCE_STALL = fstall_reg;
    assign O_DESC_RD = (dstate_reg == UES_D_REQ);
    assign O_DESC_ADDR = fetch_base_reg + {28'h0, widx_reg, 2'b00};
    assign O_DMA_CTRL = dma_ctrl_reg;
endmodule // ues_endpoint_status

// File: ues_params.svh
`ifndef UES_PARAMS_SVH
`define UES_PARAMS_SVH

// Register word offsets (byte addresses).
`define UES_OFF_STATUS 8'h00
`define UES_OFF_CLEAR 8'h04
`define UES_OFF_SET 8'h08
`define UES_OFF_RESET 8'h0c
`define UES_OFF_DISABLE 8'h10
`define UES_OFF_CONFIG 8'h14
`define UES_OFF_NEXT_DESC 8'h18
`define UES_OFF_DMA_CTRL 8'h1c
`define UES_OFF_DMA_BUF 8'h20

// Status, clear and set bit positions.
`define UES_B_SHORT 31
`define UES_B_CNT_LO 20
`define UES_B_CNT_HI 30
`define UES_B_BUSY_LO 18
`define UES_B_BUSY_HI 19
`define UES_B_BANK_LO 16
`define UES_B_BANK_HI 17
`define UES_B_NAK_OUT 15
`define UES_B_NAK_IN 14
`define UES_B_STALL 13
`define UES_B_SETUP 12
`define UES_B_TXRDY 11
`define UES_B_RXRDY 9
`define UES_B_FSTALL 5

// Config fields.
`define UES_C_TYPE_LO 0
`define UES_C_TYPE_HI 1
`define UES_C_DIR_IN 2
`define UES_C_BANKS_LO 4
`define UES_C_BANKS_HI 5
`define UES_C_NBTR_LO 6
`define UES_C_NBTR_HI 7
`define UES_C_SIZE_LO 16
`define UES_C_SIZE_HI 26
`define UES_CONFIG_RESET 32'h0000_0010

// Descriptor layout.
`define UES_DESC_OFF_NEXT 32'h0000_0000
`define UES_DESC_OFF_BUF 32'h0000_0004
`define UES_DESC_OFF_CTRL 32'h0000_0008
`define UES_DESC_ALIGN_MASK 32'hffff_fff0
`define UES_DMA_B_LOAD 1

`define UES_CNT_W 11
`define UES_DIR_BIT 7

`endif

// File: ues_pkg.sv
package ues_pkg;
    typedef enum logic [1:0]
    {
        UES_EP_CTRL,
        UES_EP_ISO,
        UES_EP_BULK,
        UES_EP_INTR
    } ues_ep_type_t;

    typedef enum
    {
        UES_D_IDLE,
        UES_D_REQ,
        UES_D_WAIT
    } ues_desc_state_t;

    typedef logic [1:0] ues_word_idx_t;
endpackage

// File: ues_endpoint_status_chk.sv
`include "ues_params.svh"
module ues_endpoint_status_chk
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_SETUP_OK,
    input wire logic I_PKT_REQ,
    input wire logic O_FORCE_STALL,
    input wire logic O_DESC_RD,
    input wire logic [31:0] O_DESC_ADDR,
    input wire logic I_DESC_RVALID,
    input wire logic [31:0] I_DESC_RDATA,
    input wire logic [31:0] O_DMA_CTRL
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] idx_reg;
    logic [1:0] idx_next;
    logic [3:0] lo_reg;
    logic [3:0] lo_next;
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    // Remembers which descriptor word is in flight, so each read and answer can be tied to its offset.
    always_comb
    begin
        idx_next = idx_reg;
        lo_next = lo_reg;
        if (O_DESC_RD)
        begin
            idx_next = (O_DESC_ADDR[3:0] == 4'h0) ? 2'h1 : idx_reg + 2'h1;
            lo_next = O_DESC_ADDR[3:0];
        end
    end
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            idx_reg <= 2'h0;
            lo_reg <= 4'h0;
        end
        else
        begin
            idx_reg <= idx_next;
            lo_reg <= lo_next;
        end
    end
    chk_desc_offset: assert property (O_DESC_RD |-> O_DESC_ADDR[3:0] inside {4'h0, 4'h4, 4'h8})
        else $error("descriptor read off a word slot");
    chk_desc_order: assert property (
        O_DESC_RD && O_DESC_ADDR[3:0] != 4'h0 |-> O_DESC_ADDR[3:0] == {idx_reg, 2'b00})
        else $error("descriptor words fetched out of order");
    chk_desc_start: assert property (O_DESC_RD && O_DESC_ADDR[3:0] == 4'h0 |-> $past(I_PKT_REQ))
        else $error("descriptor fetch without a packet request");
    chk_desc_pulse: assert property (O_DESC_RD |=> !O_DESC_RD)
        else $error("descriptor read strobe longer than one cycle");
    chk_ctrl_load: assert property (I_DESC_RVALID && lo_reg == 4'h8 |=> O_DMA_CTRL == $past(I_DESC_RDATA))
        else $error("control word not taken from the descriptor");
    chk_next_align: assert property (
        $past(I_RD) && $past(I_ADDR) == `UES_OFF_NEXT_DESC |-> O_RDATA[3:0] == 4'h0)
        else $error("next descriptor pointer not aligned");
    chk_stall_req: assert property (
        $past(I_WR) && $past(I_ADDR) == `UES_OFF_SET && $past(I_WDATA[`UES_B_FSTALL]) && !$past(I_SETUP_OK)
        |-> O_FORCE_STALL)
        else $error("force stall request not raised");
    // Bit 16 may hold the control direction, which is not a flag and survives the wipe.
    chk_reset_wipe: assert property (
        $past(I_WR, 2) && $past(I_ADDR, 2) == `UES_OFF_RESET && $past(I_WDATA[0], 2)
        && $past(I_RD) && $past(I_ADDR) == `UES_OFF_STATUS |-> {O_RDATA[31:17], O_RDATA[15:9]} == 22'h0)
        else $error("status flags survive endpoint reset");
endmodule // ues_endpoint_status_chk

bind ues_endpoint_status ues_endpoint_status_chk u_chk (.I_REF_CLK, .I_RESET_N, .I_ADDR, .I_WDATA, .I_WR,
    .I_RD, .O_RDATA, .I_SETUP_OK, .I_PKT_REQ, .O_FORCE_STALL, .O_DESC_RD, .O_DESC_ADDR, .I_DESC_RVALID,
    .I_DESC_RDATA, .O_DMA_CTRL);

// File: ues_desc_mem.sv
module ues_desc_mem
#(
    parameter logic [31:0] BASE = 32'h0000_1230,
    parameter logic [31:0] NEXT = 32'h0000_1270,
    parameter logic [31:0] BUF = 32'h0000_4000,
    parameter logic [31:0] CTRL = 32'h0001_0000,
    parameter int LAT = 3
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rd,
    input wire logic [31:0] i_addr,
    output logic o_rvalid,
    output logic [31:0] o_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] word_reg;
    logic [31:0] last_reg;
    logic busy_reg;
    logic slow_reg;
    int wait_cnt;
    // Descriptor on a 16-byte boundary linking to another one: next, buffer, control.
    function automatic logic [31:0] fetch(input logic [31:0] a);
        case (a - BASE)
            32'h0: return NEXT;
            32'h4: return BUF;
            32'h8: return CTRL;
            default: return 32'h0bad_0bad;
        endcase
    endfunction
    // Answers alternate between prompt and slow; the data lines show junk outside the valid cycle.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy_reg <= 1'b0;
            slow_reg <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            last_reg <= 32'h0;
            wait_cnt <= 0;
        end
        else
        begin
            o_rvalid <= 1'b0;
            o_rdata <= ~last_reg;
            if (i_rd)
            begin
                busy_reg <= 1'b1;
                slow_reg <= ~slow_reg;
                wait_cnt <= slow_reg ? LAT : 0;
                word_reg <= fetch(i_addr);
            end
            else if (busy_reg && wait_cnt == 0)
            begin
                busy_reg <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= word_reg;
                last_reg <= word_reg;
            end
            else if (busy_reg)
                wait_cnt <= wait_cnt - 1;
        end
    end
endmodule // ues_desc_mem

// File: test_ues_endpoint_status.sv
`include "ues_params.svh"
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_ues_endpoint_status;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] M_SETUP = 14'h0001, M_STORE = 14'h0002, M_CRC = 14'h0004, M_TOG = 14'h0008;
    localparam logic [13:0] M_DROP = 14'h0010, M_MISS = 14'h0020, M_SENT = 14'h0040, M_STALL = 14'h0080;
    localparam logic [13:0] M_NAKI = 14'h0100, M_NAKO = 14'h0200, M_UF = 14'h0400, M_FWW = 14'h0800;
    localparam logic [13:0] M_FWR = 14'h1000, M_PKT = 14'h2000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [13:0] ev = 14'h0;
    logic [7:0] byte0 = 8'h00;
    logic [10:0] nbytes = 11'h0;
    logic [31:0] rdata;
    logic force_stall;
    logic desc_rd;
    logic [31:0] desc_addr;
    logic desc_rvalid;
    logic [31:0] desc_rdata;
    logic [31:0] dma_ctrl;
    int err_count = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    ues_endpoint_status dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
        .I_RD(rd_s), .O_RDATA(rdata), .I_SETUP_OK(ev[0]), .I_SETUP_BYTE0(byte0), .I_OUT_STORED(ev[1]),
        .I_OUT_BYTES(nbytes), .I_OUT_CRC_ERR(ev[2]), .I_OUT_TOGGLE_ERR(ev[3]), .I_OUT_DROPPED(ev[4]),
        .I_IN_MISSED(ev[5]), .I_IN_SENT(ev[6]), .I_STALL_SENT(ev[7]), .I_NAK_IN(ev[8]), .I_NAK_OUT(ev[9]),
        .I_UFRAME_END(ev[10]), .I_FW_WRITE(ev[11]), .I_FW_READ(ev[12]), .I_PKT_REQ(ev[13]),
        .O_FORCE_STALL(force_stall), .O_DESC_RD(desc_rd), .O_DESC_ADDR(desc_addr), .I_DESC_RVALID(desc_rvalid),
        .I_DESC_RDATA(desc_rdata), .O_DMA_CTRL(dma_ctrl));
    ues_desc_mem mem (.i_clk(clk), .i_rst_n(rst_n), .i_rd(desc_rd), .i_addr(desc_addr), .o_rvalid(desc_rvalid),
        .o_rdata(desc_rdata));
    // Every driver assigns each input at most once per edge; wr and pulse strobes are lowered by the next task, rd lowers rd_s itself.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr_s <= w;
        rd_s <= r;
        ev <= 14'h0;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, 1'b1, a, 32'h0);
        rd_s <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [13:0] m, input logic [10:0] n, input logic [7:0] b);
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        ev <= m;
        nbytes <= n;
        byte0 <= b;
        @(posedge clk);
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rd(`UES_OFF_STATUS, v);
        `CHECK(v & m, e)
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_handshake();
        logic [31:0] v;
        st(32'hffff_ffff, 32'h0);
        rd(8'h3c, v);
        `CHECK(v, 32'h0)
        wr(`UES_OFF_SET, 32'h0000_0020);
        pulse(M_STALL, 11'h0, 8'h00);
        pulse(M_NAKI, 11'h0, 8'h00);
        pulse(M_NAKO, 11'h0, 8'h00);
        st(32'h0000_e020, 32'h0000_e020);
        `CHECK(force_stall, 1'b1)
        wr(`UES_OFF_CLEAR, 32'h0000_e020);
        st(32'h0000_e020, 32'h0);
        pulse(M_NAKI, 11'h0, 8'h00);
        wr(`UES_OFF_DISABLE, 32'h0000_0001);
        st(32'hffff_fe00, 32'h0);
    endtask
    task automatic t_setup();
        wr(`UES_OFF_CONFIG, 32'h0040_0000);
        pulse(M_SETUP, 11'h0, 8'h80);
        st(32'h0003_1000, 32'h0001_1000);
        wr(`UES_OFF_STATUS, 32'hffff_ffff);
        st(32'hffff_fe00, 32'h0001_1000);
        wr(`UES_OFF_CLEAR, 32'h0000_1000);
        st(32'h0000_1000, 32'h0);
        pulse(M_SETUP, 11'h0, 8'h00);
        st(32'h0003_1000, 32'h0000_1000);
    endtask
    task automatic t_bulk_out();
        wr(`UES_OFF_CONFIG, 32'h0040_0022);
        wr(`UES_OFF_RESET, 32'h0000_0001);
        pulse(M_STORE, 11'd10, 8'h00);
        st(32'hffff_0200, 32'h80a4_0200);
        pulse(M_STORE, 11'd64, 8'h00);
        pulse(M_STORE, 11'd5, 8'h00);
        st(32'hffff_0200, 32'h80a8_0200);
        repeat (3) pulse(M_FWR, 11'h0, 8'h00);
        st(32'h7ff0_0000, 32'h0070_0000);
        wr(`UES_OFF_CLEAR, 32'h0000_0200);
        st(32'hffff_0200, 32'h0405_0200);
        wr(`UES_OFF_CLEAR, 32'h0000_0200);
        st(32'h000f_0200, 32'h0);
    endtask
    task automatic t_iso_out();
        wr(`UES_OFF_CONFIG, 32'h0040_0091);
        wr(`UES_OFF_RESET, 32'h0000_0001);
        st(32'hffff_fe00, 32'h0);
        pulse(M_STORE | M_CRC | M_TOG, 11'd64, 8'h00);
        pulse(M_STORE, 11'd64, 8'h00);
        st(32'h0000_3a00, 32'h0000_3a00);
        wr(`UES_OFF_CLEAR, 32'h0000_1200);
        pulse(M_STORE, 11'd64, 8'h00);
        st(32'h0000_3a00, 32'h0000_0200);
        pulse(M_MISS, 11'h0, 8'h00);
        st(32'h0000_1000, 32'h0000_1000);
        wr(`UES_OFF_CLEAR, 32'h0000_1000);
        pulse(M_DROP, 11'h0, 8'h00);
        st(32'h0000_1000, 32'h0000_1000);
    endtask
    task automatic t_iso_in();
        wr(`UES_OFF_CONFIG, 32'h0040_00a5);
        wr(`UES_OFF_RESET, 32'h0000_0001);
        repeat (5) pulse(M_FWW, 11'h0, 8'h00);
        st(32'h7ff0_0000, 32'h0050_0000);
        wr(`UES_OFF_SET, 32'h0000_0800);
        st(32'h7fff_0000, 32'h0005_0000);
        pulse(M_SENT, 11'h0, 8'h00);
        pulse(M_UF, 11'h0, 8'h00);
        st(32'h0000_2000, 32'h0000_2000);
        wr(`UES_OFF_SET, 32'h0000_0800);
        pulse(M_UF, 11'h0, 8'h00);
        st(32'h000f_4000, 32'h0000_4000);
    endtask
    task automatic t_desc();
        logic [31:0] v;
        int i;
        wr(`UES_OFF_NEXT_DESC, 32'h0000_1235);
        rd(`UES_OFF_NEXT_DESC, v);
        `CHECK(v, 32'h0000_1230)
        wr(`UES_OFF_DMA_CTRL, 32'h0000_0002);
        pulse(M_PKT, 11'h0, 8'h00);
        pulse(14'h0, 11'h0, 8'h00);
        for (i = 0; i < 60 && dma_ctrl !== 32'h0001_0000; i++)
            @(negedge clk);
        @(posedge clk);
        if (i == 60)
        begin
            err_count++;
            final_report();
        end
        else
        begin
            `CHECK(dma_ctrl, 32'h0001_0000)
            rd(`UES_OFF_DMA_BUF, v);
            `CHECK(v, 32'h0000_4000)
            rd(`UES_OFF_NEXT_DESC, v);
            `CHECK(v, 32'h0000_1270)
        end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_handshake();
        t_setup();
        t_bulk_out();
        t_iso_out();
        t_iso_in();
        t_desc();
        final_report();
    end
endmodule // test_ues_endpoint_status
